// ---- rtl/pcg_pkg.sv ----
// package of register map, field layout and reset values for the crc generator
package pcg_pkg;
  // register byte addresses
  localparam logic [4:0] OFF_CTRL_ONE = 5'h00;
  localparam logic [4:0] OFF_CTRL_TWO = 5'h04;
  localparam logic [4:0] OFF_TAPS_LOW = 5'h08;
  localparam logic [4:0] OFF_TAPS_HIGH = 5'h0C;
  localparam logic [4:0] OFF_INPUT_LOW = 5'h10;
  localparam logic [4:0] OFF_INPUT_HIGH = 5'h14;
  localparam logic [4:0] OFF_RESULT = 5'h18;
  localparam logic [4:0] OFF_IRQ_STAT = 5'h1C;
  // second page of registers above 0x1C
  localparam logic [5:0] OFF_IRQ_MASK = 6'h20;
  // control one field positions
  localparam int BIT_MODULE_ON = 15;
  localparam int BIT_IDLE_HALT = 13;
  localparam int POS_WORD_COUNT = 8;
  localparam int BIT_FULL = 7;
  localparam int BIT_EMPTY = 6;
  localparam int BIT_IRQ_SEL = 5;
  localparam int BIT_RUN = 4;
  localparam int BIT_LSB_FIRST = 3;
  // control two field positions
  localparam int POS_DATA_WIDTH = 8;
  localparam int POS_POLY_LEN = 0;
  // reset values
  localparam logic [15:0] RST_CTRL_ONE = 16'h0020;
  localparam logic [15:0] RST_CTRL_TWO = 16'h0000;
  localparam logic [15:0] RST_TAPS = 16'h0000;
  // fifo depths
  localparam logic [4:0] DEPTH_WIDE = 5'h08;
  localparam logic [4:0] DEPTH_NARROW = 5'h10;
  localparam logic [4:0] POLY_LEN_NARROW_MAX = 5'h07;
  // interrupt status bits
  localparam int IRQ_BIT_EMPTY = 0;
  localparam int IRQ_BIT_DONE = 1;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_LOAD = 2'b01,
    ST_SHIFT = 2'b10
  } pcg_state_type;
endpackage

// ---- rtl/pcg_crc_gen.sv ----
// programmable crc generator with data fifo and axi4-lite register slave
// Overview of operation
// R1: polynomial length is length field plus one
// R2: set tap bit inserts xor at that position
// R3: constant term always applied
// R4: highest term n always included
// R5: data word width is width field plus one
// R6: module off resets engine, fifo, data, result
// R7: idle halt stops operation while system idles
// R8: word count, at most 8 or 16
// R9: full flag when fifo holds maximum words
// R10: empty flag when fifo holds no words
// R11: interrupt on fifo empty or shift done
// R12: run bit starts or stops shift engine
// R13: lsb first select chooses bit order
// R14: low taps bit 0 reads zero
// R15: one bit per clock, result held after
// R16: software writes data only when not full
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the address map.
module pcg_crc_gen (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // system idle mode indication
  input wire logic sys_idle,
  // axi4-lite write address
  input wire logic [5:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  output logic irq
);
  // configuration registers
  logic module_on_r, idle_halt_r, irq_source_sel_r, shifter_run_r, lsb_first_sel_r;
  logic [4:0] data_width_sel_r, poly_length_sel_r;
  logic [15:0] poly_taps_low_r, poly_taps_high_r;
  logic [1:0] irq_stat_r, irq_mask_r;
  // fifo, engine and result
  logic [31:0] fifo_mem [0:15];
  logic [3:0] wr_ptr_r, rd_ptr_r;
  logic [4:0] fifo_word_count_r;
  logic [31:0] input_word_r, shift_word_r, crc_r, result_word_r;
  logic [4:0] bit_cnt_r;
  pcg_pkg::pcg_state_type state_r;
  // bus slave state
  logic aw_hold_r, w_hold_r;
  logic [5:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // derived controls
  logic [4:0] depth_max;
  logic fifo_full_flag, fifo_empty_flag, active, wr_fire, rd_fire, push, pop;
  logic in_lo_wr, in_hi_wr, bad_wr;
  logic [31:0] taps, len_mask, next_crc;
  logic [4:0] n_top;
  logic in_bit, fb;
  logic [15:0] ctrl_one_rd, ctrl_two_rd;
  logic [5:0] ar_word;
  assign depth_max = (poly_length_sel_r > pcg_pkg::POLY_LEN_NARROW_MAX) ?
                     pcg_pkg::DEPTH_WIDE : pcg_pkg::DEPTH_NARROW; // R8
  assign fifo_full_flag = (fifo_word_count_r == depth_max); // R9
  assign fifo_empty_flag = (fifo_word_count_r == 5'h00); // R10
  assign active = module_on_r && !(idle_halt_r && sys_idle); // R7
  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign in_lo_wr = wr_fire && (aw_addr_r == {1'b0, pcg_pkg::OFF_INPUT_LOW});
  assign in_hi_wr = wr_fire && (aw_addr_r == {1'b0, pcg_pkg::OFF_INPUT_HIGH});
  // a push is lost when the fifo is full
  assign push = in_lo_wr && module_on_r && !fifo_full_flag; // R16
  assign pop = active && shifter_run_r && (state_r == pcg_pkg::ST_IDLE) && !fifo_empty_flag; // R12
  assign bad_wr = wr_fire && (aw_addr_r[5:2] > pcg_pkg::OFF_IRQ_MASK[5:2]);

  // polynomial taps: constant term forced, top term n forced at position n-1 feedback
  assign taps = {poly_taps_high_r, poly_taps_low_r[15:1], 1'b1}; // R2 R3
  assign n_top = poly_length_sel_r; // R1 R4
  // generate per-bit mask of the active register length
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi++) begin : g_mask
      assign len_mask[gi] = (5'(gi) <= n_top);
    end
  endgenerate
  // next remainder for one input bit, order chosen by lsb first select
  always_comb begin
    in_bit = lsb_first_sel_r ? shift_word_r[0] : shift_word_r[data_width_sel_r]; // R13 R5
    fb = crc_r[n_top] ^ in_bit; // R4
    next_crc = ({crc_r[30:0], 1'b0} ^ (fb ? taps : 32'h0000_0000)) & len_mask; // R2
  end

  // configuration register writes, unaffected by module off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      module_on_r <= pcg_pkg::RST_CTRL_ONE[pcg_pkg::BIT_MODULE_ON];
      idle_halt_r <= pcg_pkg::RST_CTRL_ONE[pcg_pkg::BIT_IDLE_HALT];
      irq_source_sel_r <= pcg_pkg::RST_CTRL_ONE[pcg_pkg::BIT_IRQ_SEL];
      lsb_first_sel_r <= pcg_pkg::RST_CTRL_ONE[pcg_pkg::BIT_LSB_FIRST];
      data_width_sel_r <= pcg_pkg::RST_CTRL_TWO[12:8];
      poly_length_sel_r <= pcg_pkg::RST_CTRL_TWO[4:0];
      poly_taps_low_r <= pcg_pkg::RST_TAPS;
      poly_taps_high_r <= pcg_pkg::RST_TAPS;
      irq_mask_r <= 2'h0;
    end else if (wr_fire) begin
      if (aw_addr_r == {1'b0, pcg_pkg::OFF_CTRL_ONE}) begin
        if (w_strb_r[1]) begin
          module_on_r <= w_data_r[pcg_pkg::BIT_MODULE_ON];
          idle_halt_r <= w_data_r[pcg_pkg::BIT_IDLE_HALT];
        end
        if (w_strb_r[0]) begin
          irq_source_sel_r <= w_data_r[pcg_pkg::BIT_IRQ_SEL];
          lsb_first_sel_r <= w_data_r[pcg_pkg::BIT_LSB_FIRST];
        end
      end else if (aw_addr_r == {1'b0, pcg_pkg::OFF_CTRL_TWO}) begin
        if (w_strb_r[1]) data_width_sel_r <= w_data_r[12:8];
        if (w_strb_r[0]) poly_length_sel_r <= w_data_r[4:0];
      end else if (aw_addr_r == {1'b0, pcg_pkg::OFF_TAPS_LOW}) begin
        if (w_strb_r[1]) poly_taps_low_r[15:8] <= w_data_r[15:8];
        if (w_strb_r[0]) poly_taps_low_r[7:0] <= {w_data_r[7:1], 1'b0}; // R14
      end else if (aw_addr_r == {1'b0, pcg_pkg::OFF_TAPS_HIGH}) begin
        if (w_strb_r[1]) poly_taps_high_r[15:8] <= w_data_r[15:8];
        if (w_strb_r[0]) poly_taps_high_r[7:0] <= w_data_r[7:0];
      end else if (aw_addr_r == pcg_pkg::OFF_IRQ_MASK) begin
        if (w_strb_r[0]) irq_mask_r <= w_data_r[1:0];
      end
    end
  end

  // run bit: written by software, held clear while module is off
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on_r) begin
      shifter_run_r <= 1'b0; // R6
    end else if (wr_fire && aw_addr_r == {1'b0, pcg_pkg::OFF_CTRL_ONE} && w_strb_r[0]) begin
      shifter_run_r <= w_data_r[pcg_pkg::BIT_RUN]; // R12
    end
  end

  // input data register: low half pushes the assembled word
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on_r) begin
      input_word_r <= 32'h0000_0000; // R6
    end else if (in_hi_wr) begin
      input_word_r[31:16] <= w_data_r[15:0];
    end else if (in_lo_wr) begin
      input_word_r[15:0] <= w_data_r[15:0];
    end
  end

  // fifo storage
  always_ff @(posedge aclk) begin
    if (push) fifo_mem[wr_ptr_r] <= {input_word_r[31:16], w_data_r[15:0]};
  end

  // fifo pointers and word count
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on_r) begin
      wr_ptr_r <= 4'h0; // R6
      rd_ptr_r <= 4'h0;
      fifo_word_count_r <= 5'h00;
    end else begin
      if (push) wr_ptr_r <= (5'(wr_ptr_r) + 5'h01 == depth_max) ? 4'h0 : wr_ptr_r + 4'h1;
      if (pop) rd_ptr_r <= (5'(rd_ptr_r) + 5'h01 == depth_max) ? 4'h0 : rd_ptr_r + 4'h1;
      if (push && !pop) fifo_word_count_r <= fifo_word_count_r + 5'h01; // R8
      else if (pop && !push) fifo_word_count_r <= fifo_word_count_r - 5'h01;
    end
  end

  // shift engine: one data bit per clock
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on_r) begin
      state_r <= pcg_pkg::ST_IDLE; // R6
      shift_word_r <= 32'h0000_0000;
      bit_cnt_r <= 5'h00;
      crc_r <= 32'h0000_0000;
      result_word_r <= 32'h0000_0000;
    end else if (active) begin // R7
      case (state_r)
        pcg_pkg::ST_IDLE: begin
          if (pop) begin
            shift_word_r <= fifo_mem[rd_ptr_r];
            bit_cnt_r <= data_width_sel_r; // R5
            state_r <= pcg_pkg::ST_SHIFT;
          end
        end
        pcg_pkg::ST_SHIFT: begin
          if (!shifter_run_r) begin
            state_r <= pcg_pkg::ST_IDLE; // R12
          end else begin
            crc_r <= next_crc; // R15
            shift_word_r <= lsb_first_sel_r ? {1'b0, shift_word_r[31:1]} :
                            {shift_word_r[30:0], 1'b0};
            bit_cnt_r <= bit_cnt_r - 5'h01;
            if (bit_cnt_r == 5'h00) begin
              result_word_r <= next_crc; // R15
              state_r <= pcg_pkg::ST_IDLE;
            end
          end
        end
        default: state_r <= pcg_pkg::ST_IDLE;
      endcase
    end
  end

  // in msb-first mode the first bit is the word's bit at the data width: no realign on load
  // note: msb path reads shift_word_r[width], shifting left keeps next bit there

  // interrupt status: sticky, write one to clear, set wins
  logic ev_empty, ev_done;
  assign ev_empty = pop && fifo_word_count_r == 5'h01 && !push; // R11
  assign ev_done = active && state_r == pcg_pkg::ST_SHIFT && shifter_run_r &&
                   bit_cnt_r == 5'h00 && fifo_empty_flag; // R11
  always_ff @(posedge aclk) begin
    if (!aresetn || !module_on_r) begin
      irq_stat_r <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (wr_fire && aw_addr_r == {1'b0, pcg_pkg::OFF_IRQ_STAT} && w_strb_r[0] && w_data_r[i])
          irq_stat_r[i] <= 1'b0;
      end
      if (ev_empty && irq_source_sel_r) irq_stat_r[pcg_pkg::IRQ_BIT_EMPTY] <= 1'b1; // R11
      if (ev_done && !irq_source_sel_r) irq_stat_r[pcg_pkg::IRQ_BIT_DONE] <= 1'b1; // R11
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) irq <= 1'b0;
    else irq <= |(irq_stat_r & irq_mask_r);
  end

  // axi write channels: capture address and data in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= 6'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_r && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[5:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= bad_wr ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read view of control registers
  assign ctrl_one_rd = {module_on_r, 1'b0, idle_halt_r, fifo_word_count_r, fifo_full_flag,
                        fifo_empty_flag, irq_source_sel_r, shifter_run_r, lsb_first_sel_r, 3'b000};
  assign ctrl_two_rd = {3'b000, data_width_sel_r, 3'b000, poly_length_sel_r};
  // word-aligned read address, byte lanes ignored for every register
  assign ar_word = {s_axi_araddr[5:2], 2'b00};

  // axi read channel with address decode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        if (ar_word == {1'b0, pcg_pkg::OFF_CTRL_ONE})
          s_axi_rdata <= {16'h0000, ctrl_one_rd};
        else if (ar_word == {1'b0, pcg_pkg::OFF_CTRL_TWO})
          s_axi_rdata <= {16'h0000, ctrl_two_rd};
        else if (ar_word == {1'b0, pcg_pkg::OFF_TAPS_LOW})
          s_axi_rdata <= {16'h0000, poly_taps_low_r[15:1], 1'b0}; // R14
        else if (ar_word == {1'b0, pcg_pkg::OFF_TAPS_HIGH})
          s_axi_rdata <= {16'h0000, poly_taps_high_r};
        else if (ar_word == {1'b0, pcg_pkg::OFF_INPUT_LOW})
          s_axi_rdata <= {16'h0000, input_word_r[15:0]};
        else if (ar_word == {1'b0, pcg_pkg::OFF_INPUT_HIGH})
          s_axi_rdata <= {16'h0000, input_word_r[31:16]};
        else if (ar_word == {1'b0, pcg_pkg::OFF_RESULT})
          s_axi_rdata <= result_word_r; // R15
        else if (ar_word == {1'b0, pcg_pkg::OFF_IRQ_STAT})
          s_axi_rdata <= {30'h0000_0000, irq_stat_r};
        else if (ar_word == pcg_pkg::OFF_IRQ_MASK)
          s_axi_rdata <= {30'h0000_0000, irq_mask_r};
        else begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ---- tb/pcg_crc_gen_sva.sv ----
// bus handshake, read-back and reset checks for the crc generator
module pcg_crc_gen_sva (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write channels
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [5:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // interrupt
  input wire logic irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // read address accepted in this cycle
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
  property p_b_after;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_b_after: assert property (p_b_after) else $error("write response late");
  property p_r_after;
    ar_hs |=> s_axi_rvalid;
  endproperty
  a_r_after: assert property (p_r_after) else $error("read data late");
  property p_rst_quiet;
    disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq && !s_axi_arready;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active in reset");
  property p_unmapped;
    ar_hs && s_axi_araddr[5:2] > 4'h8 |=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
  property p_taps_low;
    ar_hs && s_axi_araddr == {1'b0, pcg_pkg::OFF_TAPS_LOW} |=>
      !s_axi_rdata[0] && s_axi_rdata[31:16] == 16'h0;
  endproperty
  a_taps_low: assert property (p_taps_low) else $error("taps low bit zero set");
  property p_flags;
    ar_hs && s_axi_araddr == {1'b0, pcg_pkg::OFF_CTRL_ONE} |=> !(s_axi_rdata[7] && s_axi_rdata[6])
      && s_axi_rdata[12:8] <= 5'h10 && s_axi_rdata[2:0] == 3'h0;
  endproperty
  a_flags: assert property (p_flags) else $error("fifo flags inconsistent");
endmodule
bind pcg_crc_gen pcg_crc_gen_sva i_pcg_crc_gen_sva (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
);

// ---- tb/pcg_crc_gen_tb.sv ----
// self-checking bench driving the crc generator over its register bus
module pcg_crc_gen_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [5:0] A_C1 = 6'(pcg_pkg::OFF_CTRL_ONE);
  localparam logic [5:0] A_C2 = 6'(pcg_pkg::OFF_CTRL_TWO);
  localparam logic [5:0] A_TL = 6'(pcg_pkg::OFF_TAPS_LOW);
  localparam logic [5:0] A_TH = 6'(pcg_pkg::OFF_TAPS_HIGH);
  localparam logic [5:0] A_RS = 6'(pcg_pkg::OFF_RESULT);
  localparam logic [5:0] A_ST = 6'(pcg_pkg::OFF_IRQ_STAT);
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sys_idle = 1'b0;
  logic [5:0] s_axi_awaddr = 6'h00;
  logic [5:0] s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd, ex;
  logic [1:0] br;
  int bad_count = 0;
  int samples_checked = 0;
  // crc cases: length, taps, data width, bit order
  logic [4:0] pl_t [4] = '{5'h0F, 5'h0F, 5'h1F, 5'h04};
  logic [31:0] tp_t [4] = '{32'h1021, 32'h1021, 32'h04C11DB7, 32'h5};
  logic [4:0] dw_t [4] = '{5'h07, 5'h07, 5'h1F, 5'h0C};
  logic ls_t [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
  logic [31:0] wd [3] = '{32'h9A3C5E71, 32'h000000FF, 32'h80012468};
  // free-running system clock
  always #5 aclk = ~aclk;
  pcg_crc_gen i_pcg_crc_gen (
    .aclk, .aresetn, .sys_idle, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq
  );
  // reference shift of one word into the remainder
  function automatic logic [31:0] crc_step(logic [31:0] c, logic [4:0] pl, logic [31:0] tp,
                                           logic [31:0] w, logic [4:0] dw, logic ls);
    logic fb;
    logic [32:0] m;
    m = (33'h1 << (pl + 1)) - 33'h1;
    for (int i = 0; i <= dw; i++) begin
      fb = c[pl] ^ (ls ? w[i] : w[dw - i]);
      c = ((c << 1) ^ (fb ? (tp | 32'h1) : 32'h0)) & m[31:0];
    end
    return c;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // write with address and data offered together
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    ex = {30'h0, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  // a data word goes in as high half then low half
  task automatic push(input logic [31:0] w);
    wr(6'(pcg_pkg::OFF_INPUT_HIGH), {16'h0, w[31:16]});
    wr(6'(pcg_pkg::OFF_INPUT_LOW), {16'h0, w[15:0]});
  endtask
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 2000) begin
      @(posedge aclk);
      n++;
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    repeat (30000) @(posedge aclk);
    bad_count++;
    results();
  end
  // main sequence
  initial begin
    int dp;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(A_C1);
    chk("ctrl one reset", 32'h20, rd & 32'hFFBF);
    wr(A_C2, 32'hFFFFFFFF);
    rd_reg(A_C2);
    chk("ctrl two fields", 32'h1F1F, rd);
    wr(A_TL, 32'hFFFFFFFF);
    rd_reg(A_TL);
    chk("taps low", 32'hFFFE, rd);
    wr(A_TH, 32'hFFFFFFFF);
    rd_reg(A_TH);
    chk("taps high", 32'hFFFF, rd);
    rd_reg(6'h24);
    chk("unmapped resp", 32'h2, ex);
    wr(6'h24, 32'h0);
    chk("unmapped bresp", 32'h2, 32'(br));
    for (int k = 0; k < 4; k++) begin
      wr(A_C1, 32'h0);
      wr(A_C2, {19'h0, dw_t[k], 3'h0, pl_t[k]});
      wr(A_TL, {16'h0, tp_t[k][15:0]});
      wr(A_TH, {16'h0, tp_t[k][31:16]});
      wr(6'(pcg_pkg::OFF_IRQ_MASK), 32'h2);
      wr(A_C1, {16'h0, 12'h800, ls_t[k], 3'h0});
      ex = 32'h0;
      for (int j = 0; j < 3; j++) begin
        push(wd[j]);
        ex = crc_step(ex, pl_t[k], tp_t[k], wd[j], dw_t[k], ls_t[k]);
      end
      dp = int'(ex);
      wr(A_C1, {16'h0, 12'h801, ls_t[k], 3'h0});
      wait_irq();
      chk("done irq", 32'h1, 32'(irq));
      rd_reg(A_RS);
      chk("result", 32'(dp), rd);
      wr(A_ST, 32'h3);
      rd_reg(A_ST);
      chk("status cleared", 32'h0, rd);
      chk("irq cleared", 32'h0, 32'(irq));
      wr(A_C1, 32'h0);
      rd_reg(A_RS);
      chk("result off", 32'h0, rd);
      rd_reg(A_TL);
      chk("taps kept", {16'h0, tp_t[k][15:1], 1'b0}, rd);
    end
    for (int k = 0; k < 2; k++) begin
      dp = k ? 16 : 8;
      wr(A_C1, 32'h0);
      wr(A_C2, k ? 32'h0F07 : 32'h0F0F);
      wr(6'(pcg_pkg::OFF_IRQ_MASK), 32'h1);
      wr(A_C1, 32'h8020);
      for (int j = 0; j < dp; j++) push(32'(j));
      rd_reg(A_C1);
      chk("fifo full", 32'({dp[4:0], 8'h80}), rd & 32'h1FC0);
      sys_idle <= 1'b1;
      wr(A_C1, 32'hA030);
      repeat (30) @(posedge aclk);
      rd_reg(A_C1);
      chk("idle hold", 32'(dp) << 8, rd & 32'h1F00);
      sys_idle <= 1'b0;
      wait_irq();
      rd_reg(A_ST);
      chk("empty event", 32'h1, rd);
      rd_reg(A_C1);
      chk("drained", 32'h40, rd & 32'h1FC0);
    end
    results();
  end
endmodule
